// ==== src/tape_station_write_read_sequencer.v ====
// Station-side state counter, delay counter and NRZ write toggles of a
// seven-track tape station, with an APB register slave.
// Assumes the controller pins and the station clock are asynchronous to pclk;
// every one passes two flip-flops before use.
// Summary of operation
// [RULE1] Write toggle flips on one bit only
// [RULE2] Controller sends all-ones after three idle characters
// [RULE3] Check char signal blocks toggle reset side
// [RULE4] Controller ends only after check char read
// [RULE5] End request clears connect on station clock; code clears it only in forward state 7
// [RULE6] End in forward state 7 enters state 3
// [RULE7] Delay counter cleared on entering state 7
// [RULE8] State 3 exits after 5.3 ms stop delay
// [RULE9] Forward reselection leaves state 3 at once
// [RULE10] Selection: state 0 one clock, then state 6
// [RULE11] State 6 turns capstan motor on
// [RULE12] Read off load point waits 5.5 ms
// [RULE13] Read at load point waits 29.9 ms
// [RULE14] Counter held while load point marker seen
// [RULE15] Proceed only in state 7 while connected
// [RULE16] Controller reads only after proceed received
// [RULE17] Write waits 6.5 ms prewrite delay in state 6; code never leaves state 6 when the erase bit is set and read is clear
// [RULE18] Counter and states step per station clock
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "tape_seq_defs.vh"
module tape_station_write_read_sequencer (
    input wire pclk, // Block clock, 250 MHz
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [31:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output wire pready, // APB ready, always high
    output wire pslverr, // APB error on unmapped address
    input wire station_clock, // Station clock from link
    input wire ctrl_end_request, // End of operation from controller
    input wire write_check_char, // Write check character level
    input wire load_point_marker, // Load point sensor
    input wire [6:0] wr_char, // Character bits from controller
    input wire wr_char_valid, // Character strobe, rising edge
    output wire char_ready, // FIFO can take a character
    output reg [6:0] write_toggle_out, // Write toggle states
    output reg capstan_motor_on, // Capstan motor power
    output reg capstan_motor_off, // Inverse of motor power
    output reg device_proceed_out, // Device proceed to controller
    output reg station_connected_to_ctrl // Connect flip-flop copy
);

    localparam integer STOP_CYC = `CYC_UP(`STOP_DELAY_NS);
    localparam integer PREREAD_CYC = `CYC_UP(`PREREAD_DELAY_NS);
    localparam integer PREWRITE_CYC = `CYC_UP(`PREWRITE_DELAY_NS);
    localparam integer LOADPT_CYC = `CYC_UP(`LOADPT_DELAY_NS);
    localparam [6:0] TOG_RST = `TOGGLE_RESET;
    localparam [2:0] ST_0 = `STATE_0;
    localparam [2:0] ST_3 = `STATE_3;
    localparam [2:0] ST_6 = `STATE_6;
    localparam [2:0] ST_7 = `STATE_7;

    // State code match, used for the state wire and selection decodes
    function state_is;
        input [2:0] st;
        input [2:0] code;
        begin
            state_is = (st == code);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    wire [`SYNC_W-1:0] async_in;
    reg [`SYNC_W-1:0] sync1_q;
    reg [`SYNC_W-1:0] sync2_q;
    reg clk_prev_q;
    reg valid_prev_q;
    wire tick;
    wire char_strobe;
    wire end_sync;
    wire check_sync;
    wire lp_sync;
    wire [6:0] char_sync;
    assign async_in = {wr_char_valid, wr_char, load_point_marker, write_check_char,
                       ctrl_end_request, station_clock};

    // Two flip-flops per pin; stage one feeds stage two only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= {`SYNC_W{1'b0}};
            sync2_q <= {`SYNC_W{1'b0}};
            clk_prev_q <= 1'b0;
            valid_prev_q <= 1'b0;
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
            clk_prev_q <= sync2_q[0];
            valid_prev_q <= sync2_q[11];
        end
    end

    // [RULE18] one step per station clock
    assign tick = sync2_q[0] & ~clk_prev_q;
    assign char_strobe = sync2_q[11] & ~valid_prev_q;
    assign end_sync = sync2_q[1];
    assign check_sync = sync2_q[2];
    assign lp_sync = sync2_q[3];
    assign char_sync = sync2_q[10:4];

    ////////////////////////////////////////////////////////////////////////////
    // APB slave
    reg [2:0] ctrl_q;
    reg sel_pend_q;
    reg connect_q;
    reg [2:0] state_q;
    reg [`CNT_W-1:0] cnt_q;
    reg lp_start_q;
    wire [`FIFO_AW:0] fifo_count;
    wire [7:0] addr_lo;
    wire apb_wr;
    wire sel_write;
    wire sel_take;
    wire mapped;

    assign addr_lo = paddr[7:0];
    assign pready = 1'b1;
    assign mapped = (paddr[31:8] == 24'h000000) &&
                    (addr_lo == `REG_CTRL_OFS || addr_lo == `REG_STATUS_OFS || addr_lo == `REG_DELAY_OFS);
    assign pslverr = psel & penable & ~mapped;
    assign apb_wr = psel & penable & pwrite & mapped;
    assign sel_write = apb_wr & (addr_lo == `REG_CTRL_OFS) & pwdata[`CTRL_SELECT_BIT];

    // Order fields: read, forward, erase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CTRL_RESET;
        end else if (apb_wr && addr_lo == `REG_CTRL_OFS) begin
            ctrl_q <= pwdata[`CTRL_ERASE_BIT:`CTRL_READ_BIT];
        end
    end

    // Selection request, set wins over consume
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_pend_q <= 1'b0;
        end else if (sel_write) begin
            sel_pend_q <= 1'b1;
        end else if (sel_take) begin
            sel_pend_q <= 1'b0;
        end
    end

    // Read data mux
    always @* begin
        prdata = 32'h00000000;
        if (psel && !pwrite) begin
            case (addr_lo)
                `REG_CTRL_OFS: begin
                    prdata[`CTRL_ERASE_BIT:`CTRL_READ_BIT] = ctrl_q;
                end
                `REG_STATUS_OFS: begin
                    prdata[`ST_CONNECT_BIT] = connect_q;
                    prdata[`ST_STATE_LSB+2:`ST_STATE_LSB] = state_q;
                    prdata[`ST_CAPSTAN_BIT] = capstan_motor_on;
                    prdata[`ST_PROCEED_BIT] = device_proceed_out;
                    prdata[`ST_SELPEND_BIT] = sel_pend_q;
                    prdata[`ST_LOADPT_BIT] = lp_sync;
                    prdata[`ST_TOGGLE_LSB+6:`ST_TOGGLE_LSB] = write_toggle_out;
                    prdata[`ST_FIFO_LSB+`FIFO_AW:`ST_FIFO_LSB] = fifo_count;
                end
                `REG_DELAY_OFS: begin
                    prdata[`CNT_W-1:0] = cnt_q;
                end
                default: prdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State counter and delay counter
    wire read_operation_sel;
    wire new_order_forward;
    wire forward_motion_sel;
    wire erase_or_load_point;
    wire in_state_three;
    wire in_state_six;
    wire in_state_seven;
    wire preread_delay_done;
    wire read_delay_qualified;
    wire load_point_delay_done;
    wire prewrite_done;
    wire stop_delay_done;
    wire stop_delay_exit;
    wire exit_six;
    assign read_operation_sel = ctrl_q[0];
    assign new_order_forward = ctrl_q[1];
    assign forward_motion_sel = ctrl_q[1];
    assign erase_or_load_point = ctrl_q[2] | lp_start_q;
    assign in_state_three = state_is(state_q, ST_3);
    assign in_state_six = state_is(state_q, ST_6);
    assign in_state_seven = state_is(state_q, ST_7);

    // Selection accepted only when idle or in the stop delay
    assign sel_take = tick & sel_pend_q & ~connect_q & (state_is(state_q, ST_0) | in_state_three);

    // [RULE12] preread delay off load point
    assign preread_delay_done = (cnt_q >= PREREAD_CYC[`CNT_W-1:0]) & ~erase_or_load_point;
    assign read_delay_qualified = read_operation_sel & preread_delay_done;
    // [RULE13] longer delay at load point
    assign load_point_delay_done = read_operation_sel & erase_or_load_point & (cnt_q >= LOADPT_CYC[`CNT_W-1:0]);
    // [RULE17] prewrite delay
    assign prewrite_done = ~read_operation_sel & ~ctrl_q[2] & (cnt_q >= PREWRITE_CYC[`CNT_W-1:0]);
    assign exit_six = connect_q & (read_delay_qualified | load_point_delay_done | prewrite_done);

    // [RULE8] stop delay decode
    assign stop_delay_done = (cnt_q >= STOP_CYC[`CNT_W-1:0]);
    // [RULE9] forward reselection cuts stop delay
    assign stop_delay_exit = stop_delay_done | (connect_q & new_order_forward);

    // State bits, connect flip-flop, delay counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_0;
            connect_q <= 1'b0;
            cnt_q <= `CNT_ZERO;
            lp_start_q <= 1'b0;
        end else if (tick) begin
            if (sel_take) begin
                connect_q <= 1'b1;
            end
            case (state_q)
                ST_0: begin
                    // [RULE10] one clock in state 0
                    if (connect_q) begin
                        state_q <= ST_6;
                        cnt_q <= `CNT_ZERO;
                        lp_start_q <= lp_sync;
                    end
                end
                ST_6: begin
                    if (exit_six) begin
                        // [RULE7] fresh count in state 7
                        state_q <= ST_7;
                        cnt_q <= `CNT_ZERO;
                    // [RULE14] hold counter on marker
                    end else if (!lp_sync && cnt_q != `CNT_MAX) begin
                        cnt_q <= cnt_q + `CNT_ONE;
                    end
                end
                ST_7: begin
                    // [RULE5] [RULE6] end drops connect, state 3
                    if (end_sync && forward_motion_sel) begin
                        connect_q <= 1'b0;
                        state_q <= ST_3;
                        cnt_q <= `CNT_ZERO;
                    end
                end
                ST_3: begin
                    // [RULE8] [RULE9] leave stop delay
                    if (stop_delay_exit) begin
                        state_q <= ST_0;
                        cnt_q <= `CNT_ZERO;
                    end else begin
                        cnt_q <= cnt_q + `CNT_ONE;
                    end
                end
                default: begin
                    state_q <= ST_0;
                    cnt_q <= `CNT_ZERO;
                end
            endcase
        end
    end

    // [RULE11] [RULE15] motor and proceed outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capstan_motor_on <= 1'b0;
            capstan_motor_off <= 1'b1;
            device_proceed_out <= 1'b0;
            station_connected_to_ctrl <= 1'b0;
        end else begin
            capstan_motor_on <= state_q[0];
            capstan_motor_off <= ~state_q[0];
            device_proceed_out <= in_state_seven & connect_q;
            station_connected_to_ctrl <= connect_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Character FIFO and write toggles
    wire fifo_out_valid;
    wire [6:0] fifo_out_data;
    wire drain;
    wire write_active;

    // Drain stalls outside a connected write in state 7
    assign write_active = connect_q & ~read_operation_sel & in_state_seven;
    assign drain = tick & write_active & fifo_out_valid;

    char_fifo #(
        .WIDTH(`TRACKS),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(char_strobe),
        .in_ready(char_ready),
        .in_data(char_sync),
        .out_valid(fifo_out_valid),
        .out_ready(drain),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // One toggle per track; all set while not writing
    genvar gi;
    generate
        for (gi = 0; gi < `TRACKS; gi = gi + 1) begin : g_trk
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    write_toggle_out[gi] <= TOG_RST[gi];
                end else if (!connect_q || read_operation_sel) begin
                    write_toggle_out[gi] <= 1'b1;
                end else if (drain && fifo_out_data[gi]) begin
                    // [RULE3] reset side blocked for check char
                    if (check_sync) begin
                        write_toggle_out[gi] <= 1'b1;
                    // [RULE1] NRZ toggle on a one bit
                    end else begin
                        write_toggle_out[gi] <= ~write_toggle_out[gi];
                    end
                end
            end
        end
    endgenerate

endmodule

// ==== src/tape_seq_defs.vh ====
// Constants for the tape station write/read sequencer.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef TAPE_SEQ_DEFS_VH
`define TAPE_SEQ_DEFS_VH

// APB register offsets (byte addresses)
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define REG_DELAY_OFS 8'h08

// Control register fields
`define CTRL_SELECT_BIT 0
`define CTRL_READ_BIT 1
`define CTRL_FORWARD_BIT 2
`define CTRL_ERASE_BIT 3
`define CTRL_RESET 3'h2

// Status register fields
`define ST_CONNECT_BIT 0
`define ST_STATE_LSB 1
`define ST_CAPSTAN_BIT 4
`define ST_PROCEED_BIT 5
`define ST_SELPEND_BIT 6
`define ST_LOADPT_BIT 7
`define ST_TOGGLE_LSB 8
`define ST_FIFO_LSB 16

// State counter codes: {bit one, bit two, bit three}
`define STATE_0 3'h0
`define STATE_3 3'h6
`define STATE_6 3'h3
`define STATE_7 3'h7

// Link and data widths
`define TRACKS 7
`define CNT_W 11
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define SYNC_W 12

// Timing in nanoseconds, and station clock period
`define STATION_CLK_NS 16700
`define STOP_DELAY_NS 5300000
`define PREREAD_DELAY_NS 5500000
`define PREWRITE_DELAY_NS 6500000
`define LOADPT_DELAY_NS 29900000

// Least times round up to whole station clocks
`define CYC_UP(t) (((t) + `STATION_CLK_NS - 1) / `STATION_CLK_NS)

// Reset values and counter constants
`define TOGGLE_RESET 7'h7F
`define CNT_ZERO 11'h000
`define CNT_ONE 11'h001
`define CNT_MAX 11'h7FF

`endif

// ==== src/char_fifo.v ====
// Character FIFO between controller link and the write toggles.
// Assumes a single clock; both sides use valid/ready handshakes.
`timescale 1ns/1ps
module char_fifo #(
    parameter WIDTH = 7,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk, // Block clock
    input wire rst_n, // Async reset, active low
    input wire in_valid, // Write side offers a word
    output wire in_ready, // FIFO not full
    input wire [WIDTH-1:0] in_data, // Word to store
    output wire out_valid, // FIFO not empty
    input wire out_ready, // Drain side takes a word
    output wire [WIDTH-1:0] out_data, // Oldest word
    output wire [AW:0] count // Words held
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    // Handshake and flags
    assign in_ready = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_q];
    assign count = count_q;

    // Storage array, no reset needed
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and fill level
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule

// ==== test/seq_checker_assertions.sv ====
// Port checker for the tape station sequencer.
// Assumes a bind onto the top module; all checks run on pclk.
`timescale 1ns/1ps
module seq_checker (
    input wire pclk, // Clock
    input wire presetn, // Reset, low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pslverr, // APB error
    input wire station_clock, // Link clock
    input wire ctrl_end_request, // End request
    input wire write_check_char, // Check char
    input wire [6:0] write_toggle_out, // Toggles
    input wire capstan_motor_on, // Motor on
    input wire capstan_motor_off, // Motor off
    input wire device_proceed_out, // Proceed
    input wire station_connected_to_ctrl // Connect
);
    reg [2:0] lk_q;
    reg [10:0] run_q;
    ////////////////////////////////////////
    // Station ticks counted while the motor runs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_q <= 3'h0;
            run_q <= 11'h000;
        end else begin
            lk_q <= {lk_q[1:0], station_clock};
            if (!capstan_motor_on)
                run_q <= 11'h000;
            else if (lk_q[1] && !lk_q[2] && run_q != 11'h7FF)
                run_q <= run_q + 11'h001;
        end
    end
    ////////////////////////////////////////
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence end_in_seven;
        (device_proceed_out && ctrl_end_request) [*4];
    endsequence
    pslverr_in_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside an access");
    end_drop_a: assert property (
        end_in_seven |-> ##[1:40] (!device_proceed_out && !station_connected_to_ctrl && capstan_motor_off))
        else $error("end request did not stop the station");
    motor_conn_a: assert property (
        $rose(capstan_motor_on) |-> station_connected_to_ctrl && $past(station_connected_to_ctrl, 10))
        else $error("motor started without a held connect");
    proceed_gate_a: assert property (
        device_proceed_out |-> station_connected_to_ctrl && capstan_motor_on)
        else $error("proceed outside connected state seven");
    proceed_delay_a: assert property ($rose(device_proceed_out) |-> run_q >= 11'h140)
        else $error("proceed came before the start delay");
    motor_inverse_a: assert property (capstan_motor_off != capstan_motor_on)
        else $error("motor outputs not inverse");
    toggle_idle_a: assert property ((!station_connected_to_ctrl) [*4] |-> write_toggle_out == 7'h7F)
        else $error("toggles not set while disconnected");
    lrc_sets_a: assert property (
        write_check_char [*5] |=> ((write_toggle_out & $past(write_toggle_out)) == $past(write_toggle_out)))
        else $error("toggle cleared during check char");
endmodule
bind tape_station_write_read_sequencer seq_checker chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
    .station_clock(station_clock), .ctrl_end_request(ctrl_end_request),
    .write_check_char(write_check_char), .write_toggle_out(write_toggle_out),
    .capstan_motor_on(capstan_motor_on), .capstan_motor_off(capstan_motor_off),
    .device_proceed_out(device_proceed_out), .station_connected_to_ctrl(station_connected_to_ctrl)
);

// ==== test/ctrl_model.sv ====
// Controller model: station clock, characters, check char and end.
// Assumes pclk from the bench; outputs other than the station clock change just after pclk edges.
`timescale 1ns/1ps
module ctrl_model (
    input wire pclk, // Block clock
    input wire device_proceed_out, // Proceed from station
    output logic station_clock, // Station clock, free running
    output logic [6:0] wr_char, // Character bits
    output logic wr_char_valid, // Character strobe
    output logic write_check_char, // Check char level
    output logic ctrl_end_request // End of operation
);
    ////////////////////////////////////////
    // Station clock, 48 ns, off the pclk grid
    initial begin
        station_clock = 1'b0;
        wr_char = 7'h00;
        wr_char_valid = 1'b0;
        write_check_char = 1'b0;
        ctrl_end_request = 1'b0;
        #1;
        forever #24 station_clock = ~station_clock;
    end
    ////////////////////////////////////////
    // One character; bits settle first and are scrambled after
    task send_char(input logic [6:0] c);
        @(posedge pclk);
        wr_char <= c;
        repeat (2) @(posedge pclk);
        wr_char_valid <= 1'b1;
        repeat (4) @(posedge pclk);
        wr_char_valid <= 1'b0;
        repeat (4) @(posedge pclk);
        wr_char <= ~c;
    endtask
    // pause three characters, then all ones
    task check_char;
        repeat (3) @(posedge station_clock);
        @(posedge pclk);
        write_check_char <= 1'b1;
        send_char(7'h7F);
        repeat (4) @(posedge station_clock);
        @(posedge pclk);
        write_check_char <= 1'b0;
    endtask
    task end_op;
        int i;
        for (i = 0; i < 20000 && device_proceed_out !== 1'b1; i++)
            @(posedge pclk);
        ctrl_end_request <= 1'b1;
        for (i = 0; i < 100 && device_proceed_out !== 1'b0; i++)
            @(posedge pclk);
        @(posedge pclk);
        ctrl_end_request <= 1'b0;
    endtask
endmodule

// ==== test/testbench.sv ====
// Bench for the sequencer: write, read, reselect, load point.
// Assumes the design, controller model and checker are compiled.
`timescale 1ns/1ps
`include "tape_seq_defs.vh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic station_clock, ctrl_end_request, write_check_char, wr_char_valid, char_ready;
    logic capstan_motor_on, capstan_motor_off, device_proceed_out, station_connected_to_ctrl;
    logic load_point_marker;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [6:0] wr_char, write_toggle_out, tog;
    realtime t0, t1;
    int n_mismatch = 0;
    int checks_done = 0;
    localparam logic [31:0] A_CT = {24'h000000, `REG_CTRL_OFS};
    localparam logic [31:0] A_ST = {24'h000000, `REG_STATUS_OFS};
    localparam logic [31:0] A_DL = {24'h000000, `REG_DELAY_OFS};
    localparam logic [31:0] SM = 32'h0000000E;
    localparam logic [31:0] S0 = {28'h0000000, `STATE_0, 1'b0};
    localparam logic [31:0] S6 = {28'h0000000, `STATE_6, 1'b0};
    localparam logic [31:0] S7 = {28'h0000000, `STATE_7, 1'b0};
    tape_station_write_read_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .station_clock(station_clock),
        .ctrl_end_request(ctrl_end_request), .write_check_char(write_check_char),
        .load_point_marker(load_point_marker), .wr_char(wr_char), .wr_char_valid(wr_char_valid),
        .char_ready(char_ready), .write_toggle_out(write_toggle_out),
        .capstan_motor_on(capstan_motor_on), .capstan_motor_off(capstan_motor_off),
        .device_proceed_out(device_proceed_out), .station_connected_to_ctrl(station_connected_to_ctrl));
    ctrl_model ctrl (.pclk(pclk), .device_proceed_out(device_proceed_out),
        .station_clock(station_clock), .wr_char(wr_char), .wr_char_valid(wr_char_valid),
        .write_check_char(write_check_char), .ctrl_end_request(ctrl_end_request));
    ////////////////////////////////////////
    // Clock, watchdog, verdict
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #400000;
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // Compare helpers and bus cycles
    task chk(input logic [31:0] g, x, input string w);
        checks_done++;
        if (g !== x) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h want %h", $time, w, g, x);
        end
    endtask
    task rng(input realtime a, b, input int lo, hi, input string w);
        int n;
        n = int'((b - a) / 48.0);
        checks_done++;
        if (n < lo || n > hi) begin
            n_mismatch++;
            $display("[FAIL] %0t %s took %0d ticks", $time, w, n);
        end
    endtask
    task apb(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic er);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [31:0] a, output logic [31:0] d);
        apb(1'b0, a, 32'h00000000, d, e);
    endtask
    task wr(input logic [31:0] a, d);
        apb(1'b1, a, d, q, e);
    endtask
    task wait_sts(input logic [31:0] m, v, input int lim, output realtime t);
        logic [31:0] s;
        int i;
        for (i = 0; i < lim; i++) begin
            rd(A_ST, s);
            if ((s & m) === v)
                break;
        end
        t = $realtime;
        @(posedge pclk);
        chk(s & m, v, "status wait");
    endtask
    ////////////////////////////////////////
    // Scenarios
    task s_reset;
        chk(write_toggle_out, 7'h7F, "toggles");
        chk({capstan_motor_on, capstan_motor_off, device_proceed_out}, 3'h2, "motor");
        chk({station_connected_to_ctrl, char_ready, pready}, 3'h3, "connect");
        rd(A_CT, q);
        chk(q, 32'h00000004, "ctrl reset");
        rd(A_ST, q);
        chk(q, 32'h00007F00, "status reset");
        apb(1'b1, 32'h0000000C, 32'hFFFFFFFF, q, e);
        chk(e, 1'b1, "unmapped write");
        rd(32'h0000000C, q);
        chk({q[30:0], e}, 32'h00000001, "unmapped read");
    endtask
    task s_write;
        int i;
        tog = 7'h7F;
        for (i = 0; i < 16; i++) begin
            ctrl.send_char(7'(i * 9 + 5));
            tog = tog ^ 7'(i * 9 + 5);
        end
        rd(A_ST, q);
        chk({char_ready, q[20:16]}, 6'h10, "buffer full");
        wr(A_CT, 32'h00000005);
        wait_sts(SM, S6, 100, t0);
        chk({station_connected_to_ctrl, capstan_motor_on}, 2'h3, "prewrite");
        wait_sts(SM, S7, 3000, t1);
        rng(t0, t1, 388, 394, "prewrite delay");
        wait_sts(32'h001F0000, 32'h00000000, 2000, t1);
        chk(write_toggle_out, tog, "nrz toggles");
        ctrl.check_char();
        chk(write_toggle_out, 7'h7F, "check char");
        ctrl.end_op();
        rd(A_ST, q);
        chk(q[5:0], 6'h0C, "stop state");
        t0 = $realtime;
        rd(A_DL, q);
        rng(0.0, 48.0 * q, 0, 4, "counter restart");
        wait_sts(SM, S0, 2000, t1);
        rng(t0, t1, 316, 321, "stop delay");
    endtask
    task s_read;
        wr(A_CT, 32'h00000007);
        wait_sts(32'h0000000F, 32'h00000001, 100, t0);
        wait_sts(SM, S6, 100, t1);
        rng(t0, t1, 0, 1, "state zero hold");
        wait_sts(SM, S7, 3000, t1);
        rng(t0, t1, 329, 334, "preread delay");
        chk(device_proceed_out, 1'b1, "proceed");
        ctrl.end_op();
        wr(A_CT, 32'h00000007);
        wait_sts(SM, S6, 40, t1);
        wait_sts(SM, S7, 3000, t1);
        ctrl.end_op();
        wait_sts(SM, S0, 2000, t1);
    endtask
    task s_load_point;
        @(posedge pclk);
        load_point_marker <= 1'b1;
        wr(A_CT, 32'h00000007);
        wait_sts(SM, S6, 100, t0);
        repeat (480) @(posedge pclk);
        rd(A_DL, q);
        chk(q, 32'h00000000, "held counter");
        load_point_marker <= 1'b0;
        wait_sts(SM, S7, 10000, t1);
        rng(t0, t1, 1826, 1838, "load point delay");
        ctrl.end_op();
        wait_sts(SM, S0, 2000, t1);
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        load_point_marker = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_write();
        s_read();
        s_load_point();
        complete_run();
    end
endmodule
